// file: hdl/mfs_tx_end.sv
// Transmitting end: stripes flow tag plus flit bytes across the active lanes.
`timescale 1ns/1ns
`default_nettype none
module mfs_tx_end (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // Mode controls
  input  wire logic [1:0]                   widthSel,
  input  wire logic                         degradedMode,
  input  wire logic                         latencyOpt,
  // Link-layer flit request
  input  wire logic                         flitValid,
  input  wire logic [15:0]                  flowTagField,
  input  wire logic [mfs_pkg::FLIT_BITS-1:0] flitData,
  input  wire logic                         ioTlpEndsAtFlit,
  input  wire logic                         ioMorePending,
  output logic                              flitReady,
  output logic                              widthError,
  // Lanes
  mfs_link_if.tx                            link
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int XB = mfs_pkg::XFER_BYTES;

  mfs_pkg::mfs_state_e          state_r, state_nxt;
  logic [XB*8-1:0]              shift_r;
  logic [mfs_pkg::IDX_W-1:0]    byteIdx_r;
  logic [mfs_pkg::SYM_W-1:0]    blkSym_r;
  logic [2:0]                   lanes_r;
  logic                         sync_r;
  logic                         idlePend_r;
  logic [7:0]                   laneByte_r [4];
  logic [3:0]                   laneValid_r;
  logic [1:0]                   laneSync_r;
  logic                         syncValid_r;
  logic                         start_r;
  logic                         ready_r;
  logic                         widthErr_r;

  // Single lane is refused unless degraded; an illegal request falls back to four lanes.
  wire logic       wantOne   = (widthSel == mfs_pkg::MFS_W1);
  wire logic       badWidth  = (wantOne && !degradedMode) || (widthSel == 2'h3);
  wire logic [2:0] reqLanes  = badWidth ? 3'h4 : (widthSel == mfs_pkg::MFS_W2) ? 3'h2 :
                               wantOne ? 3'h1 : 3'h4;
  wire logic       idleGo    = idlePend_r && !flitValid;
  wire logic       takeNew   = (state_r == mfs_pkg::MFS_IDLE) && (flitValid || idleGo);
  wire logic       blkFull   = sync_r && (blkSym_r == 5'(mfs_pkg::BLOCK_SYMS));
  wire logic       lastSym   = ({1'b0, byteIdx_r} + 8'(lanes_r)) >= 8'(XB);
  // Idle flit carries the I/O tag with an all-idle body.
  wire logic [XB*8-1:0] idleWord = {{mfs_pkg::FLIT_BYTES{mfs_pkg::IDLE_BYTE}}, mfs_pkg::IO_TAG};
  wire logic [XB*8-1:0] newWord  = flitValid ? {flitData, flowTagField} : idleWord;
  // A full block stalls the data path two cycles, the second being the header cycle, so that the header lands on a block edge.
  wire logic                      dataCyc   = (state_r == mfs_pkg::MFS_DATA) && !blkFull;
  wire logic                      syncCyc   = (state_r == mfs_pkg::MFS_SYNC);
  wire logic [XB*8-1:0]           shiftNext = shift_r >> (lanes_r * 8);
  wire logic [mfs_pkg::IDX_W-1:0] idxNext   = byteIdx_r + 7'(lanes_r);
  wire logic [3:0]                laneMask;
  wire logic [7:0]                laneNext [4];

  // Lane i is live when it lies below the lane count latched for this transfer.
  function automatic logic laneOn(input int lane, input logic [2:0] count);
    return 3'(lane) < count;
  endfunction

  for (genvar g = 0; g < 4; g++) begin : g_sel
    assign laneMask[g] = laneOn(g, lanes_r);
    assign laneNext[g] = laneMask[g] ? shift_r[g*8 +: 8] : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mfs_pkg::MFS_IDLE: begin
        if (takeNew) begin
          // The header decision follows the mode latched now, not the one of the last transfer.
          state_nxt = (!latencyOpt && blkSym_r == 5'h00) ? mfs_pkg::MFS_SYNC : mfs_pkg::MFS_DATA;
        end
      end
      mfs_pkg::MFS_SYNC: state_nxt = mfs_pkg::MFS_DATA;
      mfs_pkg::MFS_DATA: begin
        if (blkFull) begin
          state_nxt = mfs_pkg::MFS_SYNC;
        end else if (lastSym) begin
          state_nxt = mfs_pkg::MFS_IDLE;
        end
      end
      default: state_nxt = mfs_pkg::MFS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready follows the next state, so it drops in the cycle after a take.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r    <= mfs_pkg::MFS_IDLE;
      ready_r    <= 1'b0;
      widthErr_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      ready_r    <= (state_nxt == mfs_pkg::MFS_IDLE);
      widthErr_r <= badWidth;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Width and header mode are latched per transfer so a change never splits one.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lanes_r    <= 3'h4;
      sync_r     <= 1'b1;
      idlePend_r <= 1'b0;
    end else if (takeNew) begin
      lanes_r    <= reqLanes;
      sync_r     <= !latencyOpt;
      // An I/O TLP that closes its flit with nothing queued owes the peer an idle flit.
      idlePend_r <= flitValid && ioTlpEndsAtFlit && !ioMorePending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_r   <= '0;
      byteIdx_r <= '0;
    end else if (takeNew) begin
      shift_r   <= newWord;
      byteIdx_r <= '0;
    end else if (dataCyc) begin
      shift_r   <= shiftNext;
      byteIdx_r <= idxNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency mode keeps the block counter parked at zero.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      blkSym_r <= '0;
    end else if (syncCyc || (takeNew && latencyOpt)) begin
      blkSym_r <= '0;
    end else if (dataCyc) begin
      blkSym_r <= sync_r ? blkSym_r + 5'h01 : 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The start flag marks the symbol that carries the low tag byte on lane zero.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      laneValid_r <= '0;
      start_r     <= 1'b0;
    end else begin
      laneValid_r <= dataCyc ? laneMask : 4'h0;
      start_r     <= dataCyc && (byteIdx_r == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane bytes hold between symbols; laneValid alone marks a live symbol.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        laneByte_r[i] <= '0;
      end
    end else if (dataCyc) begin
      for (int i = 0; i < 4; i++) begin
        laneByte_r[i] <= laneNext[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The header value stays on laneSync between pulses; syncValid qualifies it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      laneSync_r  <= '0;
      syncValid_r <= 1'b0;
    end else begin
      syncValid_r <= syncCyc;
      if (syncCyc) begin
        laneSync_r <= mfs_pkg::SYNC_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign flitReady      = ready_r;
  assign widthError     = widthErr_r;
  assign link.laneValid = laneValid_r;
  assign link.laneSync  = laneSync_r;
  assign link.syncValid = syncValid_r;
  assign link.xferStart = start_r;
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign link.laneByte[g] = laneByte_r[g];
  end
endmodule
`default_nettype wire

// file: hdl/mfs_pkg.sv
// Shared constants and types for the multilane flit striper.
`default_nettype none
package mfs_pkg;
  localparam int TAG_BYTES    = 2;
  localparam int FLIT_BITS    = 528;
  localparam int FLIT_BYTES   = FLIT_BITS / 8;
  localparam int XFER_BYTES   = TAG_BYTES + FLIT_BYTES;
  localparam int MAX_LANES    = 4;
  localparam int BLOCK_SYMS   = 16;
  localparam int SYNC_BITS    = 2;
  localparam int IDX_W        = 7;
  localparam int SYM_W        = 5;
  localparam logic [1:0] SYNC_DATA = 2'h2;
  localparam logic [15:0] IO_TAG   = 16'h0001;
  localparam logic [7:0] IDLE_BYTE = 8'h00;

  typedef enum logic [1:0] {
    MFS_W4 = 2'h0,
    MFS_W2 = 2'h1,
    MFS_W1 = 2'h2
  } mfs_width_e;

  typedef enum logic [1:0] {
    MFS_IDLE = 2'h0,
    MFS_SYNC = 2'h1,
    MFS_DATA = 2'h2
  } mfs_state_e;
endpackage
`default_nettype wire

// file: hdl/mfs_link_if.sv
// Lane-side interface between the transmitting and receiving ends.
`timescale 1ns/1ns
`default_nettype none
interface mfs_link_if;
  logic [7:0] laneByte [4];
  logic [3:0] laneValid;
  logic [1:0] laneSync;
  logic       syncValid;
  logic       xferStart;
  modport tx (output laneByte, output laneValid, output laneSync, output syncValid, output xferStart);
  modport rx (input laneByte, input laneValid, input laneSync, input syncValid, input xferStart);
endinterface
`default_nettype wire

// file: hdl/mfs_rx_end.sv
// Receiving end: rebuilds flow tag plus flit and holds flit-boundary TLPs.
`timescale 1ns/1ns
`default_nettype none
module mfs_rx_end (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Mode controls
  input  wire logic [1:0]                    widthSel,
  // Lanes
  mfs_link_if.rx                             link,
  // Link-layer side
  input  wire logic                          tlpAtBoundary,
  input  wire logic                          nextIsNullify,
  output logic                               flitValid,
  output logic [15:0]                        flowTagField,
  output logic [mfs_pkg::FLIT_BITS-1:0]      flitData,
  output logic                               tlpGood,
  output logic                               tlpNullified
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int XB = mfs_pkg::XFER_BYTES;

  logic [XB*8-1:0]           acc_r;
  logic [mfs_pkg::IDX_W-1:0] cnt_r;
  logic                      valid_r;
  logic                      hold_r;
  logic                      good_r;
  logic                      null_r;

  wire logic [2:0] lanes = (widthSel == mfs_pkg::MFS_W2) ? 3'h2 :
                           (widthSel == mfs_pkg::MFS_W1) ? 3'h1 : 3'h4;
  wire logic       beat  = |link.laneValid;
  // A start beat restarts assembly at byte zero.
  wire logic [mfs_pkg::IDX_W-1:0] base = link.xferStart ? 7'h00 : cnt_r;
  wire logic [7:0] nextCnt = {1'b0, base} + 8'(lanes);
  wire logic       done    = beat && (nextCnt >= 8'(XB));
  wire logic       allIdle = (acc_r[XB*8-1:16] == '0);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_r   <= '0;
      cnt_r   <= '0;
      valid_r <= 1'b0;
      hold_r  <= 1'b0;
      good_r  <= 1'b0;
      null_r  <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      good_r  <= 1'b0;
      null_r  <= 1'b0;
      if (beat) begin
        for (int i = 0; i < 4; i++) begin
          if (3'(i) < lanes && int'(base) + i < XB) begin
            acc_r[(int'(base) + i)*8 +: 8] <= link.laneByte[i];
          end
        end
        cnt_r <= done ? 7'h00 : nextCnt[6:0];
      end
      if (done) begin
        valid_r <= 1'b1;
      end
      // A boundary TLP is released only by the flit that follows it.
      if (valid_r && hold_r) begin
        hold_r <= 1'b0;
        null_r <= nextIsNullify;
        good_r <= !nextIsNullify && allIdle;
      end else if (tlpAtBoundary) begin
        hold_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign flitValid    = valid_r;
  assign flowTagField = acc_r[15:0];
  assign flitData     = acc_r[XB*8-1:16];
  assign tlpGood      = good_r;
  assign tlpNullified = null_r;
endmodule
`default_nettype wire

// file: verif/mfs_link_monitor.sv
// Checker of lane framing seen between the two ends.
`timescale 1ns/1ns
`default_nettype none
module mfs_link_monitor (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Lane signals
  input wire logic [7:0] laneByte [4],
  input wire logic [3:0] laneValid,
  input wire logic [1:0] laneSync,
  input wire logic       syncValid,
  input wire logic       xferStart
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // The mask of the last start fixes the length that the next start must see.
  logic [6:0]      symCnt_r;
  logic [3:0]      mask_r;
  logic [4:0]      blkCnt_r;
  logic            blkSeen_r;
  wire logic [6:0] expSyms = (mask_r == 4'hf) ? 7'h11 : (mask_r == 4'h3) ? 7'h22 : 7'h44;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      symCnt_r <= 7'h0;
      mask_r <= 4'h0;
      blkCnt_r <= 5'h0;
      blkSeen_r <= 1'b0;
    end else begin
      if (xferStart) begin
        symCnt_r <= 7'h1;
        mask_r <= laneValid;
      end else if (|laneValid) begin
        symCnt_r <= symCnt_r + 7'h1;
      end
      if (syncValid) begin
        blkCnt_r <= 5'h0;
        blkSeen_r <= 1'b1;
      end else if (|laneValid) begin
        blkCnt_r <= blkCnt_r + 5'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence xferHead;
    xferStart && laneValid[0];
  endsequence
  sequence syncHdr;
    laneSync == 2'h2 && laneValid == 4'h0;
  endsequence
  start_lane0_a: assert property (xferStart |-> xferHead)
    else $error("transfer did not start on lane zero");
  lane_mask_a: assert property (laneValid inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("lane mask is not a legal width");
  sync_value_a: assert property (syncValid |-> syncHdr)
    else $error("bad sync header cycle");
  sym_count_a: assert property (xferStart && mask_r != 4'h0 |-> symCnt_r == expSyms)
    else $error("transfer length wrong");
  mask_hold_a: assert property (|laneValid && !xferStart && mask_r != 4'h0 |-> laneValid == mask_r)
    else $error("lane mask changed within a transfer");
  start_pulse_a: assert property (xferStart |=> !xferStart [*8])
    else $error("transfer start repeated too soon");
  block_len_a: assert property (syncValid && blkSeen_r |-> blkCnt_r == 5'h10)
    else $error("sync block length wrong");
  block_cap_a: assert property (blkSeen_r |-> blkCnt_r <= 5'h10)
    else $error("sync header missing after block");
  dead_lane_a: assert property (|laneValid && !laneValid[3] |-> laneByte[3] == 8'h00 && laneByte[2] == 8'h00)
    else $error("inactive lane carried data");
endmodule
`default_nettype wire

// file: verif/multilane_flit_striper_tb.sv
// Self-checking bench joining both ends over the lane interface.
`timescale 1ns/1ns
`default_nettype none
module multilane_flit_striper_tb;
  logic               sys_clk;
  logic               rst_n;
  logic [1:0]         widthSel;
  logic [1:0]         rxWidth;
  logic               degradedMode;
  logic               latencyOpt;
  logic               nextNull;
  logic               flitValid = 1'b0;
  logic [15:0]        txTag = 16'h0;
  logic [527:0]       txFlit = '0;
  logic               endsAt = 1'b0;
  logic               morePend = 1'b0;
  logic               tlpAtB = 1'b0;
  logic               flitReady, widthError, rxValid, tlpGood, tlpNull;
  logic [15:0]        rxTag;
  logic [527:0]       rxFlit;
  logic [7:0]         laneExp;
  logic               startExp;
  logic [7:0]         byteQ [$];
  logic               startQ [$];
  logic [543:0]       expQ [$];
  int                 miscompares = 0;
  int                 checks = 0;
  int                 goodN, nullN, syncN;
  mfs_link_if link ();
  mfs_tx_end u_mfs_tx_end (.sys_clk(sys_clk), .rst_n(rst_n), .widthSel(widthSel), .degradedMode(degradedMode),
    .latencyOpt(latencyOpt), .flitValid(flitValid), .flowTagField(txTag), .flitData(txFlit),
    .ioTlpEndsAtFlit(endsAt), .ioMorePending(morePend), .flitReady(flitReady), .widthError(widthError), .link(link));
  mfs_rx_end u_mfs_rx_end (.sys_clk(sys_clk), .rst_n(rst_n), .widthSel(rxWidth), .link(link),
    .tlpAtBoundary(tlpAtB), .nextIsNullify(nextNull), .flitValid(rxValid), .flowTagField(rxTag),
    .flitData(rxFlit), .tlpGood(tlpGood), .tlpNullified(tlpNull));
  mfs_link_monitor u_mfs_link_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .laneByte(link.laneByte),
    .laneValid(link.laneValid), .laneSync(link.laneSync), .syncValid(link.syncValid), .xferStart(link.xferStart));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [543:0] e, input logic [543:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // The model is a byte stream: lane order alone then fixes lane k mod N, symbol k/N.
  task automatic push(input logic [543:0] s);
    expQ.push_back(s);
    for (int k = 0; k < 68; k++) begin
      byteQ.push_back(s[8*k+:8]);
      startQ.push_back(k == 0);
    end
  endtask
  task automatic send(input logic io);
    logic [543:0] s;
    for (int i = 0; i < 17; i++) s[32*i+:32] = $urandom;
    @(posedge sys_clk);
    #1 txTag = s[15:0];
    txFlit = s[543:16];
    endsAt = 1'b1;
    morePend = !io;
    flitValid = 1'b1;
    for (int n = 0; n < 400 && flitReady !== 1'b1; n++) @(posedge sys_clk) #1;
    @(posedge sys_clk);
    push(s);
    if (io) push({{66{mfs_pkg::IDLE_BYTE}}, mfs_pkg::IO_TAG});
    #1 flitValid = 1'b0;
    chk("flitReady", 544'h0, {543'h0, flitReady});
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (rst_n === 1'b1) begin
      for (int l = 0; l < 4; l++) begin
        if (link.laneValid[l] === 1'b1) begin
          laneExp = byteQ.size() ? byteQ.pop_front() : 8'hxx;
          startExp = startQ.size() ? startQ.pop_front() : 1'bx;
          chk("laneByte", {536'h0, laneExp}, {536'h0, link.laneByte[l]});
          if (l == 0) chk("xferStart", {543'h0, startExp}, {543'h0, link.xferStart});
        end
      end
      if (rxValid === 1'b1) chk("rxFlit", expQ.size() ? expQ.pop_front() : 'x, {rxFlit, rxTag});
      if (tlpGood === 1'b1) goodN++;
      if (tlpNull === 1'b1) nullN++;
      if (link.syncValid === 1'b1) syncN++;
    end
  end
  initial begin
    void'($urandom(32'h9bd224f2));
    for (int m = 0; m < 6; m++) begin
      widthSel = (m == 4) ? 2'h2 : (m == 5) ? 2'h0 : m[1:0];
      rxWidth = (m < 3) ? m[1:0] : 2'h0;
      degradedMode = (m == 2);
      latencyOpt = (m == 5);
      nextNull = m[0];
      rst_n = 1'b0;
      byteQ.delete();
      startQ.delete();
      expQ.delete();
      repeat (16) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      goodN = 0;
      nullN = 0;
      syncN = 0;
      send(1'b0);
      send(1'b0);
      tlpAtB = 1'b1;
      send(1'b1);
      for (int n = 0; n < 600 && expQ.size() != 0; n++) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      #1 tlpAtB = 1'b0;
      chk("widthError", {543'h0, m == 3 || m == 4}, {543'h0, widthError});
      chk("syncCount", {543'h0, latencyOpt}, {543'h0, syncN == 0});
      chk("tlpGood", {543'h0, !nextNull}, {543'h0, goodN > 0});
      chk("tlpNullified", {543'h0, nextNull}, {543'h0, nullN > 0});
      chk("queueLeft", 544'h0, {480'h0, byteQ.size(), expQ.size()});
    end
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
